//--- pkg/fifo_ctl_pkg.sv
`default_nettype none

package fifo_ctl_pkg;

    // ------------------------------------------------------------
    // Geometry and fixed levels
    // ------------------------------------------------------------
    localparam int DATA_W = 9;
    localparam int ADDR_W = 14;
    localparam int PTR_W = ADDR_W + 1;
    localparam int DEPTH = 16384;
    localparam int LSB_W = 9;
    localparam int MSB_W = ADDR_W - LSB_W;
    localparam int BUF_DEPTH = 2;
    localparam logic [PTR_W-1:0] PTR_STEP = 15'h0001;
    localparam logic [PTR_W-1:0] CAP_NORMAL = 15'h4000;
    localparam logic [PTR_W-1:0] CAP_FALLTHROUGH = 15'h4001;
    localparam logic [PTR_W-1:0] HALF_LEVEL = 15'h2000;
    localparam logic [ADDR_W-1:0] OFS_DEFAULT_PARALLEL = 14'h007F;
    localparam logic [ADDR_W-1:0] OFS_DEFAULT_SERIAL = 14'h03FF;
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam logic [1:0] BUF_STEP = 2'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEL_EMPTY_LO,
        SEL_EMPTY_HI,
        SEL_FULL_LO,
        SEL_FULL_HI
    } ofs_sel_t;

    typedef struct packed {
        logic full_reset_n;
        logic access_n;
        logic serial_en_n;
        logic serial_in;
        logic replay_n;
        logic write_en_n;
        logic read_en_n;
        logic [DATA_W-1:0] data;
    } pins_t;

    localparam pins_t PINS_IDLE = '{
        full_reset_n: 1'h0, access_n: 1'h1, serial_en_n: 1'h1, serial_in: 1'h0,
        replay_n: 1'h1, write_en_n: 1'h1, read_en_n: 1'h1, data: 9'h000
    };

    function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = g;
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

`default_nettype wire

//--- rtl/fifo_ctl.sv
`default_nettype none

// ------------------------------------------------------------
// Two-flop synchroniser
// ------------------------------------------------------------
module sync_pair #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta <= INIT;
            q_out <= INIT;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule

// Notes on behaviour
// - Full reset asynchronously zeroes pointers; near-empty low, near-full and half high.
// - Mode strap sampled in full reset picks normal or fall-through flag polarity.
// - Access low in full reset: thresholds 127, parallel offset loading only.
// - Access high in full reset: thresholds 1023, serial offset loading only.
// - Offset registers can always be read back in parallel.
// - Both resets clear the data output register.
// - Soft reset asynchronously zeroes pointers and presets near and half flags.
// - Soft reset keeps the timing mode and presets its empty and full flags.
// - Soft reset leaves offsets and loading method alone.
// - Replay low on an edge starts setup and rewinds the read pointer.
// - Normal mode: empty flag low during replay setup, every read needs enable.
// - Fall-through: out-valid pin high in setup, first word falls out unasked.
// - Fall-through: first word into empty memory appears after three edges.
// - Normal mode: words appear only when requested with read enable.
// - After full reset the strap pin is serial offset data, serial method only.
// - Write enable low and not full stores the word at the next location.
// - Normal mode full flag low when full, high again three cycles after read.
// - Fall-through in-room high when full, low again three cycles after read.
// - Write enable is ignored while full.
// - Write-side flags update only on the write clock.
// - Read-side flags update only on the read clock.
// - Read enable is ignored while empty.
// - Near-empty low while stored count is at or below the empty offset.
module fifo_ctl (
    // Clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    // Resets and straps
    input wire logic FULL_RESET_N_IN,
    input wire logic SOFT_RESET_N_IN,
    input wire logic FALLTHROUGH_SELECT_SERIAL_IN_IN,
    input wire logic OFFSET_ACCESS_N_IN,
    input wire logic SERIAL_ENABLE_N_IN,
    input wire logic REPLAY_N_IN,
    // Write port
    input wire logic WRITE_ENABLE_N_IN,
    input wire logic [fifo_ctl_pkg::DATA_W-1:0] WRITE_DATA_IN,
    // Read port
    input wire logic READ_ENABLE_N_IN,
    output logic [fifo_ctl_pkg::DATA_W-1:0] READ_DATA_OUT,
    // Status
    output logic EMPTY_FLAG_N_OUT,
    output logic FULL_FLAG_N_OUT,
    output logic NEAR_EMPTY_N_OUT,
    output logic NEAR_FULL_N_OUT,
    output logic HALF_LEVEL_N_OUT,
    output logic FALLTHROUGH_MODE_OUT
);
    localparam int AW = fifo_ctl_pkg::ADDR_W;
    localparam int PW = fifo_ctl_pkg::PTR_W;
    localparam int DW = fifo_ctl_pkg::DATA_W;

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    fifo_ctl_pkg::pins_t pin_raw;
    fifo_ctl_pkg::pins_t pin;
    logic [$bits(fifo_ctl_pkg::pins_t)-1:0] pin_q;
    logic rst_ptr;

    assign pin_raw = '{full_reset_n: FULL_RESET_N_IN, access_n: OFFSET_ACCESS_N_IN,
                       serial_en_n: SERIAL_ENABLE_N_IN,
                       serial_in: FALLTHROUGH_SELECT_SERIAL_IN_IN,
                       replay_n: REPLAY_N_IN, write_en_n: WRITE_ENABLE_N_IN,
                       read_en_n: READ_ENABLE_N_IN, data: WRITE_DATA_IN};

    sync_pair #(.W($bits(fifo_ctl_pkg::pins_t)), .INIT(fifo_ctl_pkg::PINS_IDLE)) u_pins (
        .clk_in(REF_CLK_IN),
        .rst_in(RST_IN),
        .d_in(pin_raw),
        .q_out(pin_q)
    );
    assign pin = fifo_ctl_pkg::pins_t'(pin_q);

    // The data path resets straight from the pins so that it acts with no clock.
    assign rst_ptr = RST_IN | ~FULL_RESET_N_IN | ~SOFT_RESET_N_IN;

    // ------------------------------------------------------------
    // Mode strap and offset registers
    // ------------------------------------------------------------
    logic fallthrough_mode;
    logic serial_load;
    logic [AW-1:0] empty_offset;
    logic [AW-1:0] full_offset;
    fifo_ctl_pkg::ofs_sel_t wr_sel;
    fifo_ctl_pkg::ofs_sel_t rd_sel;
    logic wr_ofs;
    logic ser_ofs;
    logic rd_ofs;
    logic [DW-1:0] ofs_word;

    assign wr_ofs = ~pin.access_n & ~pin.write_en_n & ~serial_load;
    assign ser_ofs = ~pin.access_n & ~pin.serial_en_n & serial_load;
    assign rd_ofs = ~pin.access_n & ~pin.read_en_n;

    function automatic fifo_ctl_pkg::ofs_sel_t next_sel(input fifo_ctl_pkg::ofs_sel_t s);
        case (s)
            fifo_ctl_pkg::SEL_EMPTY_LO: return fifo_ctl_pkg::SEL_EMPTY_HI;
            fifo_ctl_pkg::SEL_EMPTY_HI: return fifo_ctl_pkg::SEL_FULL_LO;
            fifo_ctl_pkg::SEL_FULL_LO: return fifo_ctl_pkg::SEL_FULL_HI;
            default: return fifo_ctl_pkg::SEL_EMPTY_LO;
        endcase
    endfunction

    // Only RST_IN and the full reset touch these, so a soft reset keeps them.
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            fallthrough_mode <= 1'h0;
            serial_load <= 1'h0;
            empty_offset <= fifo_ctl_pkg::OFS_DEFAULT_PARALLEL;
            full_offset <= fifo_ctl_pkg::OFS_DEFAULT_PARALLEL;
        end else if (!pin.full_reset_n) begin
            fallthrough_mode <= pin.serial_in;
            serial_load <= pin.access_n;
            empty_offset <= pin.access_n ? fifo_ctl_pkg::OFS_DEFAULT_SERIAL
                                         : fifo_ctl_pkg::OFS_DEFAULT_PARALLEL;
            full_offset <= pin.access_n ? fifo_ctl_pkg::OFS_DEFAULT_SERIAL
                                        : fifo_ctl_pkg::OFS_DEFAULT_PARALLEL;
        end else if (wr_ofs) begin
            case (wr_sel)
                fifo_ctl_pkg::SEL_EMPTY_LO: empty_offset[fifo_ctl_pkg::LSB_W-1:0] <= pin.data;
                fifo_ctl_pkg::SEL_EMPTY_HI:
                    empty_offset[AW-1:fifo_ctl_pkg::LSB_W] <= pin.data[fifo_ctl_pkg::MSB_W-1:0];
                fifo_ctl_pkg::SEL_FULL_LO: full_offset[fifo_ctl_pkg::LSB_W-1:0] <= pin.data;
                default:
                    full_offset[AW-1:fifo_ctl_pkg::LSB_W] <= pin.data[fifo_ctl_pkg::MSB_W-1:0];
            endcase
        end else if (ser_ofs) begin
            {full_offset, empty_offset} <= {full_offset[AW-2:0], empty_offset, pin.serial_in};
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            wr_sel <= fifo_ctl_pkg::SEL_EMPTY_LO;
            rd_sel <= fifo_ctl_pkg::SEL_EMPTY_LO;
        end else if (!pin.full_reset_n) begin
            wr_sel <= fifo_ctl_pkg::SEL_EMPTY_LO;
            rd_sel <= fifo_ctl_pkg::SEL_EMPTY_LO;
        end else begin
            if (wr_ofs) begin
                wr_sel <= next_sel(wr_sel);
            end
            if (rd_ofs) begin
                rd_sel <= next_sel(rd_sel);
            end
        end
    end

    always_comb begin
        ofs_word = '0;
        case (rd_sel)
            fifo_ctl_pkg::SEL_EMPTY_LO: ofs_word = empty_offset[fifo_ctl_pkg::LSB_W-1:0];
            fifo_ctl_pkg::SEL_EMPTY_HI:
                ofs_word[fifo_ctl_pkg::MSB_W-1:0] = empty_offset[AW-1:fifo_ctl_pkg::LSB_W];
            fifo_ctl_pkg::SEL_FULL_LO: ofs_word = full_offset[fifo_ctl_pkg::LSB_W-1:0];
            default: ofs_word[fifo_ctl_pkg::MSB_W-1:0] = full_offset[AW-1:fifo_ctl_pkg::LSB_W];
        endcase
    end

    // ------------------------------------------------------------
    // Write side
    // ------------------------------------------------------------
    logic [DW-1:0] mem [fifo_ctl_pkg::DEPTH];
    logic [PW-1:0] wptr;
    logic [PW-1:0] retire;
    logic [PW-1:0] wgray_s;
    logic [PW-1:0] rgray_s;
    logic [PW-1:0] wsync;
    logic [PW-1:0] rsync;
    logic [PW-1:0] cap;
    logic [PW-1:0] next_wcount;
    logic full_state;
    logic wr_fifo;

    assign cap = fallthrough_mode ? fifo_ctl_pkg::CAP_FALLTHROUGH : fifo_ctl_pkg::CAP_NORMAL;
    // Offset access steals the write; a full memory drops it.
    assign wr_fifo = pin.access_n & ~pin.write_en_n & ~full_state;
    assign next_wcount = wptr - rsync + (wr_fifo ? fifo_ctl_pkg::PTR_STEP : '0);

    always_ff @(posedge REF_CLK_IN) begin
        if (wr_fifo) begin
            mem[wptr[AW-1:0]] <= pin.data;
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge rst_ptr) begin
        if (rst_ptr) begin
            wptr <= '0;
        end else if (wr_fifo) begin
            wptr <= wptr + fifo_ctl_pkg::PTR_STEP;
        end
    end

    // The far pointer lands two edges late, so a freed slot shows after three cycles.
    sync_pair #(.W(PW)) u_wsync (
        .clk_in(REF_CLK_IN),
        .rst_in(rst_ptr),
        .d_in(fifo_ctl_pkg::bin2gray(wptr)),
        .q_out(wgray_s)
    );
    sync_pair #(.W(PW)) u_rsync (
        .clk_in(REF_CLK_IN),
        .rst_in(rst_ptr),
        .d_in(fifo_ctl_pkg::bin2gray(retire)),
        .q_out(rgray_s)
    );
    assign wsync = fifo_ctl_pkg::gray2bin(wgray_s);
    assign rsync = fifo_ctl_pkg::gray2bin(rgray_s);

    always_ff @(posedge REF_CLK_IN or posedge rst_ptr) begin
        if (rst_ptr) begin
            full_state <= 1'h0;
            NEAR_FULL_N_OUT <= 1'h1;
            HALF_LEVEL_N_OUT <= 1'h1;
        end else begin
            full_state <= next_wcount >= cap;
            NEAR_FULL_N_OUT <= ~(next_wcount >= cap - {1'h0, full_offset});
            HALF_LEVEL_N_OUT <= ~(next_wcount > fifo_ctl_pkg::HALF_LEVEL);
        end
    end

    // ------------------------------------------------------------
    // Read side: prefetch buffer and output register
    // ------------------------------------------------------------
    logic [PW-1:0] fetch;
    logic [DW-1:0] buf_q [fifo_ctl_pkg::BUF_DEPTH];
    logic buf_head;
    logic [1:0] buf_cnt;
    logic [DW-1:0] head_data;
    logic head_valid;
    logic rd_req;
    logic take;
    logic consume;
    logic from_mem;
    logic push;
    logic pop;
    logic out_valid;
    logic next_out_valid;
    logic empty_state;
    logic replay_prev;
    logic replay_go;
    logic replay_busy;
    logic [PW-1:0] next_rcount;

    assign rd_req = pin.access_n & ~pin.read_en_n;
    assign replay_go = ~pin.replay_n & replay_prev;
    assign head_valid = (buf_cnt != '0) | (fetch != wsync);
    assign head_data = (buf_cnt != '0) ? buf_q[buf_head] : mem[fetch[AW-1:0]];

    // Normal mode pulls only on request; fall-through refills an empty output.
    always_comb begin
        if (fallthrough_mode) begin
            take = (~out_valid | (rd_req & out_valid)) & head_valid & ~replay_busy;
            consume = rd_req & out_valid;
        end else begin
            take = rd_req & ~empty_state & head_valid & ~replay_busy;
            consume = take;
        end
    end

    assign pop = take & (buf_cnt != '0);
    assign from_mem = take & (buf_cnt == '0);
    assign push = (fetch != wsync) & ~from_mem & (buf_cnt != fifo_ctl_pkg::BUF_FULL);
    assign next_out_valid = take | (out_valid & ~consume);
    assign next_rcount = wsync - retire - (consume ? fifo_ctl_pkg::PTR_STEP : '0);

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            replay_prev <= 1'h1;
        end else begin
            replay_prev <= pin.replay_n;
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge rst_ptr) begin
        if (rst_ptr) begin
            fetch <= '0;
            retire <= '0;
            buf_head <= 1'h0;
            buf_cnt <= '0;
            out_valid <= 1'h0;
            replay_busy <= 1'h0;
        end else if (replay_go) begin
            fetch <= '0;
            retire <= '0;
            buf_head <= 1'h0;
            buf_cnt <= '0;
            out_valid <= 1'h0;
            replay_busy <= 1'h1;
        end else begin
            replay_busy <= 1'h0;
            if (from_mem | push) begin
                fetch <= fetch + fifo_ctl_pkg::PTR_STEP;
            end
            if (consume) begin
                retire <= retire + fifo_ctl_pkg::PTR_STEP;
            end
            if (push) begin
                buf_q[buf_head ^ buf_cnt[0]] <= mem[fetch[AW-1:0]];
            end
            if (pop) begin
                buf_head <= ~buf_head;
            end
            buf_cnt <= buf_cnt + (push ? fifo_ctl_pkg::BUF_STEP : '0)
                               - (pop ? fifo_ctl_pkg::BUF_STEP : '0);
            out_valid <= next_out_valid;
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge rst_ptr) begin
        if (rst_ptr) begin
            empty_state <= 1'h1;
            NEAR_EMPTY_N_OUT <= 1'h0;
        end else if (replay_go) begin
            empty_state <= 1'h1;
            NEAR_EMPTY_N_OUT <= 1'h0;
        end else begin
            empty_state <= fallthrough_mode ? ~next_out_valid : (next_rcount == '0);
            NEAR_EMPTY_N_OUT <= ~(next_rcount <= {1'h0, empty_offset});
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge rst_ptr) begin
        if (rst_ptr) begin
            READ_DATA_OUT <= '0;
        end else if (rd_ofs) begin
            READ_DATA_OUT <= ofs_word;
        end else if (take) begin
            READ_DATA_OUT <= head_data;
        end
    end

    // ------------------------------------------------------------
    // Flag pins
    // ------------------------------------------------------------
    // The pin polarity swaps with the mode, which a constant reset cannot follow.
    assign EMPTY_FLAG_N_OUT = empty_state ^ ~FALLTHROUGH_MODE_OUT;
    assign FULL_FLAG_N_OUT = full_state ^ ~FALLTHROUGH_MODE_OUT;

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            FALLTHROUGH_MODE_OUT <= 1'h0;
        end else begin
            FALLTHROUGH_MODE_OUT <= fallthrough_mode;
        end
    end

endmodule

`default_nettype wire

//--- tb/fifo_ctl_assertions.sv
`default_nettype none

module fifo_ctl_assertions (
    // Clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    // Controls
    input wire logic FULL_RESET_N_IN,
    input wire logic SOFT_RESET_N_IN,
    input wire logic FALLTHROUGH_SELECT_SERIAL_IN_IN,
    input wire logic OFFSET_ACCESS_N_IN,
    input wire logic SERIAL_ENABLE_N_IN,
    input wire logic REPLAY_N_IN,
    // Data ports
    input wire logic WRITE_ENABLE_N_IN,
    input wire logic [fifo_ctl_pkg::DATA_W-1:0] WRITE_DATA_IN,
    input wire logic READ_ENABLE_N_IN,
    input wire logic [fifo_ctl_pkg::DATA_W-1:0] READ_DATA_OUT,
    // Status
    input wire logic EMPTY_FLAG_N_OUT,
    input wire logic FULL_FLAG_N_OUT,
    input wire logic NEAR_EMPTY_N_OUT,
    input wire logic NEAR_FULL_N_OUT,
    input wire logic HALF_LEVEL_N_OUT,
    input wire logic FALLTHROUGH_MODE_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    // The fill level only climbs after a write or a replay, so the age of the
    // last such request bounds when a rising level may show on the flags.
    logic quiet;
    logic [4:0] age;
    assign quiet = FULL_RESET_N_IN && SOFT_RESET_N_IN;
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            age <= 5'h1F;
        end else if (!WRITE_ENABLE_N_IN || !REPLAY_N_IN) begin
            age <= 5'h00;
        end else if (age != 5'h1F) begin
            age <= age + 5'h01;
        end
    end

    a_full_reset_out:
        assert property (!FULL_RESET_N_IN |-> READ_DATA_OUT == '0 && !NEAR_EMPTY_N_OUT
            && NEAR_FULL_N_OUT && HALF_LEVEL_N_OUT)
        else $error("full reset left outputs set");
    a_soft_reset_out:
        assert property (!SOFT_RESET_N_IN |-> READ_DATA_OUT == '0 && !NEAR_EMPTY_N_OUT
            && NEAR_FULL_N_OUT && HALF_LEVEL_N_OUT)
        else $error("soft reset left outputs set");
    a_reset_flag_mode:
        assert property (!quiet |-> EMPTY_FLAG_N_OUT == FALLTHROUGH_MODE_OUT
            && FULL_FLAG_N_OUT != FALLTHROUGH_MODE_OUT)
        else $error("reset flags do not match the mode");
    a_mode_kept:
        assert property (FULL_RESET_N_IN [*4] |=> $stable(FALLTHROUGH_MODE_OUT))
        else $error("mode moved outside full reset");
    a_read_on_request:
        assert property (!FALLTHROUGH_MODE_OUT && !$past(FALLTHROUGH_MODE_OUT) && quiet
            && $past(quiet) && $changed(READ_DATA_OUT) |-> !($past(READ_ENABLE_N_IN, 2)
            && $past(READ_ENABLE_N_IN, 3) && $past(READ_ENABLE_N_IN, 4)))
        else $error("output word changed without a read request");
    a_half_after_write:
        assert property ($fell(HALF_LEVEL_N_OUT) |-> age < 5'h0C)
        else $error("half level fell without a write");
    a_near_empty_rise:
        assert property (quiet && $rose(NEAR_EMPTY_N_OUT) |-> age < 5'h0C)
        else $error("near empty rose without a write");
    a_full_after_write:
        assert property (quiet && !FALLTHROUGH_MODE_OUT && $stable(FALLTHROUGH_MODE_OUT)
            && $fell(FULL_FLAG_N_OUT) |-> age < 5'h08)
        else $error("full flag fell without a write");
endmodule

bind fifo_ctl fifo_ctl_assertions chk (
    .REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .FULL_RESET_N_IN(FULL_RESET_N_IN),
    .SOFT_RESET_N_IN(SOFT_RESET_N_IN), .REPLAY_N_IN(REPLAY_N_IN),
    .FALLTHROUGH_SELECT_SERIAL_IN_IN(FALLTHROUGH_SELECT_SERIAL_IN_IN),
    .OFFSET_ACCESS_N_IN(OFFSET_ACCESS_N_IN), .SERIAL_ENABLE_N_IN(SERIAL_ENABLE_N_IN),
    .WRITE_ENABLE_N_IN(WRITE_ENABLE_N_IN), .WRITE_DATA_IN(WRITE_DATA_IN),
    .READ_ENABLE_N_IN(READ_ENABLE_N_IN), .READ_DATA_OUT(READ_DATA_OUT),
    .EMPTY_FLAG_N_OUT(EMPTY_FLAG_N_OUT), .FULL_FLAG_N_OUT(FULL_FLAG_N_OUT),
    .NEAR_EMPTY_N_OUT(NEAR_EMPTY_N_OUT), .NEAR_FULL_N_OUT(NEAR_FULL_N_OUT),
    .HALF_LEVEL_N_OUT(HALF_LEVEL_N_OUT), .FALLTHROUGH_MODE_OUT(FALLTHROUGH_MODE_OUT)
);

`default_nettype wire

//--- tb/fifo_reader.sv
`default_nettype none

// Reader on the far side: asks for one word at a time and waits a gap of GAP cycles, three times GAP when slow_in is high,
// long enough for the flags to settle, so it never trusts a stale flag.
module fifo_reader #(
    parameter int GAP = 6
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic go_in,
    input wire logic slow_in,
    input wire logic mode_in,
    input wire logic empty_flag_n_in,
    input wire logic [fifo_ctl_pkg::DATA_W-1:0] data_in,
    output logic read_en_n_out,
    output logic got_out,
    output logic [fifo_ctl_pkg::DATA_W-1:0] word_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int wait_left;
    logic avail;
    assign avail = empty_flag_n_in ^ mode_in;
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            read_en_n_out <= 1'b1;
            got_out <= 1'b0;
            word_out <= '0;
            wait_left <= 0;
        end else begin
            read_en_n_out <= 1'b1;
            got_out <= 1'b0;
            if (wait_left > 1) begin
                wait_left <= wait_left - 1;
            end else if (wait_left == 1) begin
                wait_left <= 0;
                got_out <= !mode_in;
                word_out <= mode_in ? word_out : data_in;
            end else if (go_in && avail) begin
                read_en_n_out <= 1'b0;
                wait_left <= slow_in ? 3 * GAP : GAP;
                got_out <= mode_in;
                word_out <= mode_in ? data_in : word_out;
            end
        end
    end
endmodule

`default_nettype wire

//--- tb/tb_fifo_ctl.sv
`default_nettype none

module tb_fifo_ctl;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic full_rst_n = 1'b0;
    logic soft_rst_n = 1'b1;
    logic sel = 1'b0;
    logic acc_n = 1'b0;
    logic rep_n = 1'b1;
    logic wen_n = 1'b1;
    logic tb_ren_n = 1'b1;
    logic go = 1'b0;
    logic slow = 1'b0;
    logic mode_exp = 1'b0;
    logic [fifo_ctl_pkg::DATA_W-1:0] wdata = 9'h000;
    logic [fifo_ctl_pkg::DATA_W-1:0] rdata, word;
    logic p_ren_n, ren_n, got, empty_n, full_n, near_e_n, near_f_n, half_n, fall_mode;
    int fails = 0;
    int num_checks = 0;
    int seed = 32'hB375;
    int k;
    int model_q[$];
    int sent_q[$];

    assign ren_n = p_ren_n & tb_ren_n;
    always #12.5 clk = ~clk;

    fifo_ctl dut (
        .REF_CLK_IN(clk), .RST_IN(rst), .FULL_RESET_N_IN(full_rst_n),
        .SOFT_RESET_N_IN(soft_rst_n), .FALLTHROUGH_SELECT_SERIAL_IN_IN(sel),
        .OFFSET_ACCESS_N_IN(acc_n), .SERIAL_ENABLE_N_IN(1'b1), .REPLAY_N_IN(rep_n),
        .WRITE_ENABLE_N_IN(wen_n), .WRITE_DATA_IN(wdata), .READ_ENABLE_N_IN(ren_n),
        .READ_DATA_OUT(rdata), .EMPTY_FLAG_N_OUT(empty_n), .FULL_FLAG_N_OUT(full_n),
        .NEAR_EMPTY_N_OUT(near_e_n), .NEAR_FULL_N_OUT(near_f_n),
        .HALF_LEVEL_N_OUT(half_n), .FALLTHROUGH_MODE_OUT(fall_mode)
    );
    fifo_reader rd (
        .clk_in(clk), .rst_in(rst), .go_in(go), .slow_in(slow), .mode_in(fall_mode),
        .empty_flag_n_in(empty_n), .data_in(rdata), .read_en_n_out(p_ren_n),
        .got_out(got), .word_out(word)
    );

    // ------------------------------------------------------------
    // Tasks, entered and left just after a rising edge
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic flags(input logic e, input logic f, input logic ne, input logic h);
        @(negedge clk);
        check(empty_n, e);
        check(full_n, f);
        check(near_e_n, ne);
        check(half_n, h);
        check(fall_mode, mode_exp);
        @(posedge clk);
    endtask

    task automatic full_reset(input logic s, input logic a);
        full_rst_n <= 1'b0;
        sel <= s;
        acc_n <= a;
        mode_exp = s;
        tick(4);
        full_rst_n <= 1'b1;
        tick(4);
        acc_n <= 1'b1;
        model_q.delete();
        sent_q.delete();
        tick(4);
    endtask

    task automatic soft_reset();
        soft_rst_n <= 1'b0;
        tick(3);
        soft_rst_n <= 1'b1;
        model_q.delete();
        sent_q.delete();
        tick(4);
        check(rdata, 9'h000);
    endtask

    task automatic write_words(input int n);
        logic [fifo_ctl_pkg::DATA_W-1:0] w;
        repeat (n) begin
            w = 9'($random(seed));
            wdata <= w;
            wen_n <= 1'b0;
            model_q.push_back(w);
            sent_q.push_back(w);
            @(posedge clk);
        end
        wen_n <= 1'b1;
    endtask

    task automatic drain(input int n);
        int got_n;
        got_n = 0;
        go <= 1'b1;
        while (got_n < n) begin
            @(negedge clk);
            if (got === 1'b1) begin
                check(word, model_q.pop_front());
                got_n++;
            end
        end
        go <= 1'b0;
        @(posedge clk);
    endtask

    task automatic ofs_read(input logic [8:0] exp);
        acc_n <= 1'b0;
        tb_ren_n <= 1'b0;
        @(posedge clk);
        acc_n <= 1'b1;
        tb_ren_n <= 1'b1;
        tick(6);
        check(rdata, exp);
    endtask

    // Enables are already high here, as the replay request demands.
    task automatic replay();
        rep_n <= 1'b0;
        @(posedge clk);
        rep_n <= 1'b1;
        model_q = sent_q;
    endtask

    task automatic fall_wait(input int exp);
        k = 0;
        while (empty_n !== 1'b0 && k < 20) begin
            @(negedge clk);
            k++;
        end
        check(k < 9, 1'b1);
        check(rdata, exp);
        @(posedge clk);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        tick(80000);
        fails++;
        print_verdict();
    end

    initial begin
        tick(2);
        rst <= 1'b0;
        full_reset(1'b0, 1'b0);
        flags(1'b0, 1'b1, 1'b0, 1'b1);
        ofs_read(9'h07F);
        acc_n <= 1'b0;
        wdata <= 9'h0C8;
        wen_n <= 1'b0;
        tick(1);
        acc_n <= 1'b1;
        write_words(200);
        tick(12);
        check(rdata, 9'h07F);
        flags(1'b1, 1'b1, 1'b0, 1'b1);
        drain(200);
        flags(1'b0, 1'b1, 1'b0, 1'b1);
        $display("test normal stream done");
        soft_reset();
        flags(1'b0, 1'b1, 1'b0, 1'b1);
        write_words(5);
        tick(10);
        drain(5);
        replay();
        tick(12);
        check(rdata, sent_q[4]);
        flags(1'b1, 1'b1, 1'b0, 1'b1);
        drain(5);
        $display("test normal replay done");
        soft_reset();
        write_words(16384);
        tick(4);
        flags(1'b1, 1'b0, 1'b1, 1'b0);
        wdata <= 9'h1AA;
        wen_n <= 1'b0;
        @(posedge clk);
        wen_n <= 1'b1;
        drain(1);
        tick(4);
        flags(1'b1, 1'b1, 1'b1, 1'b0);
        write_words(1);
        tick(4);
        flags(1'b1, 1'b0, 1'b1, 1'b0);
        soft_reset();
        flags(1'b0, 1'b1, 1'b0, 1'b1);
        check(near_f_n, 1'b1);
        $display("test fill done");
        full_reset(1'b1, 1'b1);
        flags(1'b1, 1'b0, 1'b0, 1'b1);
        ofs_read(9'h1FF);
        write_words(1);
        fall_wait(sent_q[0]);
        write_words(300);
        tick(12);
        flags(1'b0, 1'b0, 1'b0, 1'b1);
        slow <= 1'b1;
        drain(301);
        tick(4);
        flags(1'b1, 1'b0, 1'b0, 1'b1);
        replay();
        fall_wait(sent_q[0]);
        drain(301);
        slow <= 1'b0;
        $display("test fall-through done");
        soft_reset();
        flags(1'b1, 1'b0, 1'b0, 1'b1);
        write_words(200);
        tick(12);
        flags(1'b0, 1'b0, 1'b0, 1'b1);
        $display("test settings kept done");
        print_verdict();
    end
endmodule

`default_nettype wire
